// >>> rtl/div_if.sv
`timescale 1ns/100ps
`default_nettype none
interface div_if;
  import torque_limit_pkg::*;
  logic start;
  logic [DIV_W-1:0] dividend;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W-1:0] quotient;
  logic done;
  modport master (output start, output dividend, output divisor, input quotient, input done);
  modport slave (input start, input dividend, input divisor, output quotient, output done);
endinterface
`default_nettype wire

// >>> rtl/seq_divider.sv
`timescale 1ns/100ps
`default_nettype none
module seq_divider
  import torque_limit_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  div_if.slave div
);
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [DIV_CNT_W-1:0] cnt_reg, cnt_next;
  logic [DIV_W:0] rem_reg, rem_next;
  logic [DIV_W-1:0] quo_reg, quo_next;
  logic [DIV_W-1:0] dvs_reg, dvs_next;
  logic [DIV_W:0] trial;

  // One quotient bit per clock, restoring; the sequencer has thousands of idle clocks
  always_comb begin
    busy_next = busy_reg;
    done_next = 1'b0;
    cnt_next = cnt_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    dvs_next = dvs_reg;
    trial = {rem_reg[DIV_W-1:0], quo_reg[DIV_W-1]};
    if (div.start && !busy_reg) begin
      busy_next = 1'b1;
      cnt_next = DIV_CNT_W'(DIV_W - 1);
      rem_next = '0;
      quo_next = div.dividend;
      dvs_next = div.divisor;
    end else if (busy_reg) begin
      if (trial >= {1'b0, dvs_reg}) begin
        rem_next = trial - {1'b0, dvs_reg};
        quo_next = {quo_reg[DIV_W-2:0], 1'b1};
      end else begin
        rem_next = trial;
        quo_next = {quo_reg[DIV_W-2:0], 1'b0};
      end
      cnt_next = cnt_reg - 1'b1;
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      dvs_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      dvs_reg <= dvs_next;
    end
  end

  assign div.quotient = quo_reg;
  assign div.done = done_reg;
endmodule
`default_nettype wire

// >>> rtl/servo_torque_limit_select.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - After the first clock out of reset, forward output is never above the forward internal limit and reverse never above the reverse one.
// - Internal limits take 0 to 800 percent, reset to 800 and act on the next clock.
// - External limit settings take 0 to 800 percent, default 100, and act without restart.
// - With the forward external input active the forward limit is the smaller of internal and external.
// - With the forward external input inactive only the forward internal limit applies.
// - With the reverse external input active the reverse limit is the smaller of internal and external.
// - With the reverse external input inactive only the reverse internal limit applies.
// - Any selected limit above the motor maximum torque is replaced by the motor maximum.
// - The analog-limit function code enables the analog limit, captured only at reset release.
// - In analog mode each direction uses the smaller of the analog limit and its internal limit.
// - The analog limit acts in every control mode other than torque control, mode 3 included, and never in torque control.
// - The analog limit is the magnitude of the input voltage and applies to both directions.
// - The analog input is scaled by a gain of 10 to 100 in 0.1 V steps, where 30 maps 3.0 V to rated.
// - The analog input passes a first-order filter with a 0 to 65535 constant in 0.01 ms, 0 meaning none.
module servo_torque_limit_select
  import torque_limit_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fwd_ext_limit_in,
  input wire logic rev_ext_limit_in,
  input wire logic [LIMIT_W-1:0] fwd_internal_limit,
  input wire logic [LIMIT_W-1:0] rev_internal_limit,
  input wire logic [LIMIT_W-1:0] fwd_external_limit,
  input wire logic [LIMIT_W-1:0] rev_external_limit,
  input wire logic [LIMIT_W-1:0] motor_max_torque,
  input wire logic [3:0] application_function_select,
  input wire logic [6:0] analog_torque_gain,
  input wire logic [15:0] analog_input_filter_tc,
  input wire logic signed [15:0] analog_torque_mv,
  input wire logic [1:0] control_mode,
  output logic [LIMIT_W-1:0] fwd_torque_limit,
  output logic [LIMIT_W-1:0] rev_torque_limit,
  output logic analog_limit_active,
  output logic control_tick
);
  typedef enum logic [1:0] {ST_IDLE, ST_SCALE, ST_FILTER} seq_state_t;

  div_if div ();
  seq_divider u_div (
    .core_clk(core_clk),
    .rst(rst),
    .div(div)
  );

  logic fwd_meta_reg, fwd_sync_reg, rev_meta_reg, rev_sync_reg;
  logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;
  logic fwd_ext_reg, fwd_ext_next, rev_ext_reg, rev_ext_next;
  logic started_reg, started_next, analog_mode_reg, analog_mode_next;
  seq_state_t state_reg, state_next;
  logic start_reg, start_next;
  logic [DIV_W-1:0] dividend_reg, dividend_next, divisor_reg, divisor_next;
  logic [FLT_W-1:0] flt_reg, flt_next;
  logic flt_neg_reg, flt_neg_next;
  logic analog_valid_reg, analog_valid_next;
  logic analog_act_reg, analog_act_next;
  logic [LIMIT_W-1:0] fwd_out_reg, fwd_out_next, rev_out_reg, rev_out_next;

  logic [16:0] abs_mv;
  logic [6:0] gain_c;
  logic [PCT_W-1:0] pct_sat;
  logic [FLT_W-1:0] target_fx, diff_mag;
  logic [LIMIT_W-1:0] fwd_int_c, rev_int_c, fwd_ext_c, rev_ext_c, max_c, analog_c;
  logic analog_on;

  function automatic logic [LIMIT_W-1:0] clamp_setting(input logic [LIMIT_W-1:0] v);
    return (v > LIMIT_MAX) ? LIMIT_MAX : v;
  endfunction

  function automatic logic [LIMIT_W-1:0] min2(input logic [LIMIT_W-1:0] a,
                                               input logic [LIMIT_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  // Contact inputs come from pins: two flops before any logic looks at them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fwd_meta_reg <= 1'b0;
      fwd_sync_reg <= 1'b0;
      rev_meta_reg <= 1'b0;
      rev_sync_reg <= 1'b0;
    end else begin
      fwd_meta_reg <= fwd_ext_limit_in;
      fwd_sync_reg <= fwd_meta_reg;
      rev_meta_reg <= rev_ext_limit_in;
      rev_sync_reg <= rev_meta_reg;
    end
  end

  always_comb begin
    fwd_int_c = clamp_setting(fwd_internal_limit);
    rev_int_c = clamp_setting(rev_internal_limit);
    fwd_ext_c = clamp_setting(fwd_external_limit);
    rev_ext_c = clamp_setting(rev_external_limit);
    max_c = motor_max_torque;
    if (analog_torque_gain < GAIN_MIN) begin
      gain_c = GAIN_MIN;
    end else if (analog_torque_gain > GAIN_MAX) begin
      gain_c = GAIN_MAX;
    end else begin
      gain_c = analog_torque_gain;
    end
    abs_mv = analog_torque_mv[15] ? 17'(-$signed({analog_torque_mv[15], analog_torque_mv}))
                                  : {1'b0, analog_torque_mv};
    // Percent = mV / gain, since gain counts 0.1 V per rated torque
    pct_sat = (div.quotient > DIV_W'((1 << PCT_W) - 1)) ? {PCT_W{1'b1}}
                                                         : div.quotient[PCT_W-1:0];
    target_fx = {pct_sat, {FRAC_BITS{1'b0}}};
    diff_mag = (target_fx >= flt_reg) ? (target_fx - flt_reg) : (flt_reg - target_fx);
    analog_c = (flt_reg[FLT_W-1:FRAC_BITS] > PCT_W'(LIMIT_MAX)) ? LIMIT_MAX
                                                               : flt_reg[FRAC_BITS+LIMIT_W-1:FRAC_BITS];
    analog_on = analog_mode_reg && analog_valid_reg && (control_mode != MODE_TORQUE);
  end

  always_comb begin
    tick_cnt_next = tick_cnt_reg + 1'b1;
    tick_next = 1'b0;
    if (tick_cnt_reg == TICK_W'(CTRL_CYCLE_CLKS - 1)) begin
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end
    fwd_ext_next = tick_reg ? fwd_sync_reg : fwd_ext_reg;
    rev_ext_next = tick_reg ? rev_sync_reg : rev_ext_reg;
    started_next = 1'b1;
    analog_mode_next = started_reg ? analog_mode_reg
                                   : (application_function_select == APP_ANALOG_LIMIT);
    state_next = state_reg;
    start_next = 1'b0;
    dividend_next = dividend_reg;
    divisor_next = divisor_reg;
    flt_next = flt_reg;
    flt_neg_next = flt_neg_reg;
    analog_valid_next = analog_valid_reg;
    case (state_reg)
      ST_IDLE: begin
        if (tick_reg && analog_mode_reg) begin
          state_next = ST_SCALE;
          start_next = 1'b1;
          dividend_next = DIV_W'(abs_mv);
          divisor_next = DIV_W'(gain_c);
        end
      end
      ST_SCALE: begin
        if (div.done) begin
          // Step = diff * dt / (tc + dt); a zero constant gives the whole diff
          state_next = ST_FILTER;
          start_next = 1'b1;
          flt_neg_next = (target_fx < flt_reg);
          dividend_next = DIV_W'(diff_mag) * DIV_W'(FILTER_DT);
          divisor_next = DIV_W'(analog_input_filter_tc) + DIV_W'(FILTER_DT);
        end
      end
      ST_FILTER: begin
        if (div.done) begin
          state_next = ST_IDLE;
          analog_valid_next = 1'b1;
          flt_next = flt_neg_reg ? (flt_reg - div.quotient[FLT_W-1:0])
                                 : (flt_reg + div.quotient[FLT_W-1:0]);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Settings act on the next clock; only the contacts and the analog value wait for a tick
  always_comb begin
    fwd_out_next = fwd_int_c;
    rev_out_next = rev_int_c;
    if (fwd_ext_reg) begin
      fwd_out_next = min2(fwd_out_next, fwd_ext_c);
    end
    if (rev_ext_reg) begin
      rev_out_next = min2(rev_out_next, rev_ext_c);
    end
    if (analog_on) begin
      fwd_out_next = min2(fwd_out_next, analog_c);
      rev_out_next = min2(rev_out_next, analog_c);
    end
    fwd_out_next = min2(fwd_out_next, max_c);
    rev_out_next = min2(rev_out_next, max_c);
    analog_act_next = analog_on;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
      fwd_ext_reg <= 1'b0;
      rev_ext_reg <= 1'b0;
      started_reg <= 1'b0;
      analog_mode_reg <= 1'b0;
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      dividend_reg <= '0;
      divisor_reg <= '0;
      flt_reg <= '0;
      flt_neg_reg <= 1'b0;
      analog_valid_reg <= 1'b0;
      fwd_out_reg <= INTERNAL_LIMIT_RESET;
      rev_out_reg <= INTERNAL_LIMIT_RESET;
      analog_act_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
      fwd_ext_reg <= fwd_ext_next;
      rev_ext_reg <= rev_ext_next;
      started_reg <= started_next;
      analog_mode_reg <= analog_mode_next;
      state_reg <= state_next;
      start_reg <= start_next;
      dividend_reg <= dividend_next;
      divisor_reg <= divisor_next;
      flt_reg <= flt_next;
      flt_neg_reg <= flt_neg_next;
      analog_valid_reg <= analog_valid_next;
      fwd_out_reg <= fwd_out_next;
      rev_out_reg <= rev_out_next;
      analog_act_reg <= analog_act_next;
    end
  end

  assign div.start = start_reg;
  assign div.dividend = dividend_reg;
  assign div.divisor = divisor_reg;
  assign fwd_torque_limit = fwd_out_reg;
  assign rev_torque_limit = rev_out_reg;
  assign analog_limit_active = analog_act_reg;
  assign control_tick = tick_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence div_kick;
    start_reg && !u_div.busy_reg;
  endsequence
  sequence div_finish;
    ##[24:26] div.done;
  endsequence

  // Outputs leave reset at the maximum for one clock, so the caps are checked once running
  AST_FWD_INT_CAP: assert property (started_reg |=> fwd_torque_limit <= $past(fwd_int_c))
    else $error("forward limit above internal setting");
  AST_REV_INT_CAP: assert property (started_reg |=> rev_torque_limit <= $past(rev_int_c))
    else $error("reverse limit above internal setting");
  AST_FWD_EXT_ON: assert property (fwd_ext_reg |=> fwd_torque_limit <= $past(fwd_ext_c))
    else $error("forward external limit not applied");
  AST_FWD_EXT_OFF: assert property (started_reg && !fwd_ext_reg && !analog_on
    && fwd_int_c <= max_c |=> fwd_torque_limit == $past(fwd_int_c))
    else $error("forward limit differs from internal setting");
  AST_REV_EXT_ON: assert property (rev_ext_reg |=> rev_torque_limit <= $past(rev_ext_c))
    else $error("reverse external limit not applied");
  AST_REV_EXT_OFF: assert property (started_reg && !rev_ext_reg && !analog_on
    && rev_int_c <= max_c |=> rev_torque_limit == $past(rev_int_c))
    else $error("reverse limit differs from internal setting");
  AST_MAX_CAP: assert property (started_reg |=> fwd_torque_limit <= $past(max_c)
    && rev_torque_limit <= $past(max_c))
    else $error("limit above motor maximum");
  AST_TORQUE_MODE: assert property (started_reg && control_mode == MODE_TORQUE
    && !fwd_ext_reg && fwd_int_c <= max_c
    |=> fwd_torque_limit == $past(fwd_int_c) && !analog_limit_active)
    else $error("analog limit active in torque control");
  AST_ANALOG_BOTH: assert property (analog_on |=> fwd_torque_limit <= $past(analog_c)
    && rev_torque_limit <= $past(analog_c))
    else $error("analog limit not applied to both directions");
  AST_MODE_LATCH: assert property (started_reg |=> $stable(analog_mode_reg))
    else $error("analog mode changed without restart");
  AST_SAMPLE_HOLD: assert property (!tick_reg |=> $stable(fwd_ext_reg) && $stable(rev_ext_reg))
    else $error("external sample changed between ticks");
  AST_TICK_SPACING: assert property (tick_reg |=> !tick_reg [*8])
    else $error("control ticks too close");
  AST_DIV_BOUND: assert property (div_kick |-> div_finish)
    else $error("analog divide did not finish in time");
endmodule
`default_nettype wire

// >>> rtl/torque_limit_pkg.sv
`default_nettype none
package torque_limit_pkg;
  localparam int LIMIT_W = 10;
  localparam logic [LIMIT_W-1:0] LIMIT_MAX = 10'h320;
  localparam logic [LIMIT_W-1:0] INTERNAL_LIMIT_RESET = 10'h320;
  localparam logic [LIMIT_W-1:0] EXTERNAL_LIMIT_DEFAULT = 10'h064;
  localparam logic [6:0] GAIN_MIN = 7'h0A;
  localparam logic [6:0] GAIN_MAX = 7'h64;
  localparam logic [6:0] GAIN_DEFAULT = 7'h1E;
  localparam logic [3:0] APP_ANALOG_LIMIT = 4'h1;
  localparam logic [1:0] MODE_SPEED = 2'h0;
  localparam logic [1:0] MODE_POSITION = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CTRL_CYCLE_NS = 60000;
  localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
  localparam int FILTER_UNIT_NS = 10000;
  localparam int FILTER_DT = CTRL_CYCLE_NS / FILTER_UNIT_NS;
  localparam int TICK_W = 12;
  localparam int DIV_W = 24;
  localparam int DIV_CNT_W = 5;
  localparam int FRAC_BITS = 8;
  localparam int PCT_W = 12;
  localparam int FLT_W = PCT_W + FRAC_BITS;
endpackage
`default_nettype wire

// >>> sim/host_contact_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_contact_model
  import torque_limit_pkg::*;
(
  input wire logic core_clk,
  input wire logic fwd_req,
  input wire logic rev_req,
  output logic fwd_ext_limit_in,
  output logic rev_ext_limit_in
);
  // A late request is delayed, never dropped, so a contact may lag the bench by up to CTRL_CYCLE_CLKS clocks
  int fwd_age = CTRL_CYCLE_CLKS;
  int rev_age = CTRL_CYCLE_CLKS;
  initial fwd_ext_limit_in = 1'b0;
  initial rev_ext_limit_in = 1'b0;
  always @(posedge core_clk) begin
    fwd_age <= fwd_age + 1;
    rev_age <= rev_age + 1;
    if (fwd_req !== fwd_ext_limit_in && fwd_age >= CTRL_CYCLE_CLKS) begin
      fwd_ext_limit_in <= fwd_req;
      fwd_age <= 0;
    end
    if (rev_req !== rev_ext_limit_in && rev_age >= CTRL_CYCLE_CLKS) begin
      rev_ext_limit_in <= rev_req;
      rev_age <= 0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import torque_limit_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fwd_req = 1'b0;
  logic rev_req = 1'b0;
  logic fwd_pin;
  logic rev_pin;
  logic [LIMIT_W-1:0] fwd_int = 10'h320;
  logic [LIMIT_W-1:0] rev_int = 10'h320;
  logic [LIMIT_W-1:0] fwd_ext = 10'h064;
  logic [LIMIT_W-1:0] rev_ext = 10'h064;
  logic [LIMIT_W-1:0] mmax = 10'h320;
  logic [3:0] func_sel = 4'h0;
  logic [6:0] gain = 7'h1E;
  logic [15:0] filt_tc = 16'h0000;
  logic signed [15:0] ana_mv = 16'sh0000;
  logic [1:0] mode = 2'h0;
  logic [LIMIT_W-1:0] fwd_lim;
  logic [LIMIT_W-1:0] rev_lim;
  logic ana_act;
  logic tick;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'h2E9D4DD5;
  int ana_pct = 0;
  bit ana_on = 1'b0;
  real y_f = 0.0;
  int gap = -1;
  int mv_q[$] = '{3000, -1500, 9000, -9000, 4500, -600, 3000};
  int g_q[$] = '{30, 10, 100, 10, 30, 100, 30};
  int m_q[$] = '{0, 1, 2, 3, 0, 1, 0};
  int tc_q[$] = '{0, 0, 0, 0, 0, 0, 65535};

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  host_contact_model u_host_contact_model (.core_clk(core_clk), .fwd_req(fwd_req),
    .rev_req(rev_req), .fwd_ext_limit_in(fwd_pin), .rev_ext_limit_in(rev_pin));
  servo_torque_limit_select u_servo_torque_limit_select (.core_clk(core_clk), .rst(rst),
    .fwd_ext_limit_in(fwd_pin), .rev_ext_limit_in(rev_pin), .fwd_internal_limit(fwd_int),
    .rev_internal_limit(rev_int), .fwd_external_limit(fwd_ext), .rev_external_limit(rev_ext),
    .motor_max_torque(mmax), .application_function_select(func_sel), .analog_torque_gain(gain),
    .analog_input_filter_tc(filt_tc), .analog_torque_mv(ana_mv), .control_mode(mode),
    .fwd_torque_limit(fwd_lim), .rev_torque_limit(rev_lim), .analog_limit_active(ana_act),
    .control_tick(tick));

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_gap(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t tick gap got %0d exp %0d", $time, got, exp);
    end
  endtask

  function automatic int rnd(int m);
    return ($random(seed) & 32'h7FFFFFFF) % (m + 1);
  endfunction

  function automatic int lim_of(int il, int el, bit act);
    int r;
    r = il;
    if (act && el < r) r = el;
    if (ana_on && ana_pct < r) r = ana_pct;
    if (r > mmax) r = mmax;
    return r;
  endfunction

  task automatic check_all();
    chk_val(fwd_lim, lim_of(fwd_int, fwd_ext, fwd_pin === 1'b1), "fwd");
    chk_val(rev_lim, lim_of(rev_int, rev_ext, rev_pin === 1'b1), "rev");
    chk_bit(ana_act, ana_on, "analog active");
  endtask

  // Inputs change just after a tick, so one following tick latches them all
  task automatic settle();
    int n;
    n = 0;
    @(negedge core_clk);
    while (tick !== 1'b1 && n < CTRL_CYCLE_CLKS + 8) begin
      @(negedge core_clk);
      n++;
    end
    repeat (100) @(negedge core_clk);
  endtask

  always @(negedge core_clk) begin
    if (rst) begin
      gap <= -1;
    end else if (tick === 1'b1) begin
      if (gap >= 0) chk_gap(16'(gap), 16'(CTRL_CYCLE_CLKS));
      gap <= 1;
    end else if (gap >= 0) begin
      gap <= gap + 1;
    end
  end

  initial begin
    repeat (30 * CTRL_CYCLE_CLKS) @(posedge core_clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    chk_val(fwd_lim, INTERNAL_LIMIT_RESET, "reset fwd");
    chk_val(rev_lim, INTERNAL_LIMIT_RESET, "reset rev");
    chk_bit(ana_act, 1'b0, "reset analog");
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    check_all();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      fwd_int <= (i == 0) ? 10'h320 : 10'(rnd(800));
      rev_int <= (i == 0) ? 10'h000 : 10'(rnd(800));
      fwd_ext <= 10'(rnd(800));
      rev_ext <= 10'(rnd(800));
      mmax <= (i == 0) ? 10'h0FA : 10'(rnd(800));
      fwd_req <= (i == 0) ? 1'b1 : 1'(rnd(1));
      rev_req <= (i == 0) ? 1'b1 : 1'(rnd(1));
      settle();
      check_all();
      @(posedge core_clk);
      fwd_int <= 10'(rnd(800));
      rev_ext <= 10'(rnd(800));
      repeat (3) @(negedge core_clk);
      check_all();
    end
    // Second reset arms the analog limit; the function code is read only at reset release
    @(posedge core_clk);
    rst <= 1'b1;
    func_sel <= APP_ANALOG_LIMIT;
    fwd_int <= 10'h2BC;
    rev_int <= 10'h0C8;
    mmax <= 10'h320;
    fwd_req <= 1'b0;
    rev_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    foreach (mv_q[i]) begin
      @(posedge core_clk);
      ana_mv <= 16'(mv_q[i]);
      gain <= 7'(g_q[i]);
      mode <= 2'(m_q[i]);
      filt_tc <= 16'(tc_q[i]);
      if (i >= 4) func_sel <= 4'h0;
      settle();
      y_f = y_f + ((mv_q[i] < 0 ? -mv_q[i] : mv_q[i]) / g_q[i] - y_f) * FILTER_DT
        / (tc_q[i] + FILTER_DT);
      ana_pct = int'($floor(y_f));
      if (ana_pct > 800) ana_pct = 800;
      ana_on = (m_q[i] != 2);
      check_all();
    end
    stop_test();
  end
endmodule
`default_nettype wire
